// ---- sia_agent.sv ----
// serial interrupt slave agent: start, data frames and stop-width decode
//
// Behaviour
// - quiet idle: start by pulling line low one clock, then release
// - no new start while a cycle is active
// - irq level change opens start in quiet mode unless deliverable
// - continuous mode: agent never starts a cycle
// - mode changes only at stop; reset gives continuous mode
// - stop width two selects quiet, three selects continuous
// - next start no earlier than second clock after stop rise
// - count three-clock frames from start pulse rising edge
// - sample phase: pull low only if the frame level is low (irq line, or smi in frame 3)
// - release the line in every turn-around phase
// - frame n samples at clock 3n-1; lines 1..15 in frames 2..16
// - frame 3 carries irq line 2 or the management interrupt
// - smi enable bit 6 gates frame, bit 7 gates the pin
// - frame 14 carries irq line 13
// - drive and sample line on rising clock edge
// - line released in reset; reset gives continuous idle
// - sample phases driven regardless of who started the cycle
module sia_agent
    import sia_pkg::*;
#(
    parameter int NUM_IRQ = 15
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [NUM_IRQ:1] irq_i,
    input wire logic smi_i,
    input wire logic [7:0] smi_enable2_i,
    input wire logic serirq_i,
    output logic serirq_o,
    output logic serirq_oe_o,
    output logic system_management_irq_pin_o,
    output logic quiet_mode_o,
    output logic cycle_active_o
);
    // ****************************************************************
    // synchronised inputs
    // ****************************************************************
    logic [NUM_IRQ:0] raw_in;
    logic [NUM_IRQ:0] syn_in;
    logic line_s;
    logic smi_s;
    logic [NUM_IRQ:1] irq_s;

    assign raw_in = {smi_i, irq_i};
    sia_sync #(.W(NUM_IRQ + 1)) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i(raw_in),
        .q_o(syn_in)
    );
    assign irq_s = syn_in[NUM_IRQ-1:0];
    assign smi_s = syn_in[NUM_IRQ];
    // the line is driven and sampled on this very clock by every agent, so
    // it skips the synchroniser: two more flops would shift each sample
    // into the turn-around phase
    assign line_s = serirq_i;

    // ****************************************************************
    // frame-level value: level to report in each data frame
    // ****************************************************************
    function automatic logic frame_level(input logic [5:0] clk_cnt,
                                         input logic [NUM_IRQ:1] lv,
                                         input logic smi_frame_n);
        logic [5:0] fr;
        logic res;
        fr = 6'((clk_cnt + 6'h1) / 6'h3);
        res = 1'b1;
        if (fr == 6'(SIA_SMI_FRAME)) begin
            res = lv[2] & smi_frame_n;
        end else if (fr >= 6'h2 && fr <= 6'(NUM_IRQ + 1)) begin
            res = lv[fr - 6'h1];
        end
        return res;
    endfunction

    // a change seen at clock now has missed its frame once that frame's
    // drive was decided; such a change needs a fresh cycle
    function automatic logic change_missed(input logic [5:0] now,
                                           input logic [NUM_IRQ:1] diff,
                                           input logic smi_diff);
        logic res;
        res = smi_diff && now > 6'(3 * SIA_SMI_FRAME - 2);
        for (int b = 1; b <= NUM_IRQ; b++) begin
            if (diff[b] && now >= 6'(SIA_FRAME_CLKS * b + 2)) begin
                res = 1'b1;
            end
        end
        return res;
    endfunction

    // ****************************************************************
    // state registers
    // ****************************************************************
    sia_state_t st_r, st_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    logic [3:0] low_r, low_nxt;
    logic quiet_r, quiet_nxt;
    logic [NUM_IRQ:1] last_r, last_nxt;
    logic smi_last_r, smi_last_nxt;
    logic pend_r, pend_nxt;
    logic drove_r, drove_nxt;
    logic o_r, o_nxt;
    logic oe_r, oe_nxt;
    logic line_d_r;
    logic pin_r;
    logic smi_frame_n;
    logic rise;
    logic change;

    // the management interrupt is active low on the frame
    assign smi_frame_n = ~(smi_s & smi_enable2_i[SIA_SMI_SERIAL_BIT]);
    assign rise = line_s & ~line_d_r;
    assign change = (irq_s != last_r) || (smi_frame_n != smi_last_r);

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        low_nxt = low_r;
        quiet_nxt = quiet_r;
        last_nxt = last_r;
        smi_last_nxt = smi_last_r;
        pend_nxt = pend_r | change;
        drove_nxt = 1'b0;
        o_nxt = 1'b1;
        oe_nxt = 1'b0;
        unique case (st_r)
            SIA_IDLE: begin
                if (!line_s) begin
                    // someone else opened the cycle
                    st_nxt = SIA_START_LOW;
                end else if (quiet_r && pend_r) begin
                    st_nxt = SIA_START_DRV;
                    o_nxt = 1'b0;
                    oe_nxt = 1'b1;
                end
            end
            SIA_START_DRV: begin
                // released without ever driving high
                st_nxt = SIA_START_LOW;
            end
            SIA_START_LOW: begin
                if (rise) begin
                    // latch levels now; later changes start a new cycle only once their frame has passed
                    st_nxt = SIA_DATA;
                    cnt_nxt = 6'h1;
                    last_nxt = irq_s;
                    smi_last_nxt = smi_frame_n;
                    pend_nxt = 1'b0;
                end
            end
            SIA_DATA: begin
                cnt_nxt = cnt_r + 6'h1;
                // late changes join this cycle if their frame is ahead
                last_nxt = irq_s;
                smi_last_nxt = smi_frame_n;
                pend_nxt = pend_r | change_missed(cnt_r, irq_s ^ last_r,
                                                  smi_frame_n ^ smi_last_r);
                // cnt_r+1 is the sample clock about to be driven
                if (2'((cnt_r + 6'h1) % 6'h3) == SIA_PH_SAMPLE
                    && cnt_r < SIA_LAST_DATA_CLK) begin
                    if (!frame_level(cnt_r + 6'h1, irq_s, smi_frame_n)) begin
                        o_nxt = 1'b0;
                        oe_nxt = 1'b1;
                        drove_nxt = 1'b1;
                    end
                end else if (drove_r) begin
                    o_nxt = 1'b1;
                    oe_nxt = 1'b1;
                end
                if (cnt_r >= SIA_LAST_DATA_CLK) begin
                    st_nxt = SIA_STOP_WAIT;
                end
            end
            SIA_STOP_WAIT: begin
                if (!line_s) begin
                    st_nxt = SIA_STOP_LOW;
                    low_nxt = 4'h1;
                end
            end
            SIA_STOP_LOW: begin
                if (!line_s) begin
                    low_nxt = low_r + 4'h1;
                end else begin
                    if (low_r == SIA_STOP_QUIET_W) begin
                        quiet_nxt = 1'b1;
                    end else if (low_r == SIA_STOP_CONT_W) begin
                        quiet_nxt = 1'b0;
                    end
                    // a one-clock low is a late data frame, not a stop
                    if (low_r < SIA_STOP_QUIET_W) begin
                        st_nxt = SIA_STOP_WAIT;
                    end else begin
                        st_nxt = SIA_STOP_GAP;
                    end
                end
            end
            SIA_STOP_GAP: begin
                // one clock gap after stop rise before any start
                st_nxt = SIA_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // registers; line released in reset, continuous idle
    // ****************************************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= SIA_IDLE;
            cnt_r <= 6'h0;
            low_r <= 4'h0;
            quiet_r <= SIA_RESET_QUIET;
            last_r <= '1;
            smi_last_r <= 1'b1;
            pend_r <= 1'b0;
            drove_r <= 1'b0;
            o_r <= 1'b1;
            oe_r <= 1'b0;
            line_d_r <= 1'b1;
            pin_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            low_r <= low_nxt;
            quiet_r <= quiet_nxt;
            last_r <= last_nxt;
            smi_last_r <= smi_last_nxt;
            pend_r <= pend_nxt;
            drove_r <= drove_nxt;
            o_r <= o_nxt;
            oe_r <= oe_nxt;
            line_d_r <= line_s;
            pin_r <= ~(smi_s & smi_enable2_i[SIA_SMI_PIN_BIT]);
        end
    end

    assign serirq_o = o_r;
    assign serirq_oe_o = oe_r;
    assign system_management_irq_pin_o = pin_r;
    assign quiet_mode_o = quiet_r;
    assign cycle_active_o = (st_r != SIA_IDLE);

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence s_low_drive;
        serirq_oe_o && !serirq_o;
    endsequence

    property p_start_one_clock;
        @(posedge clk_i) disable iff (!rst_n_i)
        (st_r == SIA_START_DRV) |-> s_low_drive ##1 !serirq_oe_o;
    endproperty
    a_start_one_clock: assert property (p_start_one_clock)
        else $error("start pulse not one clock then release");

    property p_no_start_continuous;
        @(posedge clk_i) disable iff (!rst_n_i)
        (st_r == SIA_IDLE && !quiet_r) |=> st_r != SIA_START_DRV;
    endproperty
    a_no_start_continuous: assert property (p_no_start_continuous)
        else $error("agent started cycle in continuous mode");

    property p_no_start_active;
        @(posedge clk_i) disable iff (!rst_n_i)
        (st_r != SIA_IDLE) |=> !(st_r == SIA_START_DRV
                                 && $past(st_r) != SIA_IDLE);
    endproperty
    a_no_start_active: assert property (p_no_start_active)
        else $error("start issued while cycle active");

    property p_recover_high;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_low_drive and (st_r == SIA_DATA) |=> serirq_oe_o && serirq_o
                                             ##1 !serirq_oe_o;
    endproperty
    a_recover_high: assert property (p_recover_high)
        else $error("recovery/turn-around drive wrong");

    property p_mode_quiet;
        @(posedge clk_i) disable iff (!rst_n_i)
        (st_r == SIA_STOP_LOW && line_s && low_r == SIA_STOP_QUIET_W)
        |=> quiet_r;
    endproperty
    a_mode_quiet: assert property (p_mode_quiet)
        else $error("two-clock stop did not select quiet");

    property p_mode_cont;
        @(posedge clk_i) disable iff (!rst_n_i)
        (st_r == SIA_STOP_LOW && line_s && low_r == SIA_STOP_CONT_W)
        |=> !quiet_r;
    endproperty
    a_mode_cont: assert property (p_mode_cont)
        else $error("three-clock stop did not select continuous");

    property p_mode_only_stop;
        @(posedge clk_i) disable iff (!rst_n_i)
        $changed(quiet_r) |-> $past(st_r) == SIA_STOP_LOW;
    endproperty
    a_mode_only_stop: assert property (p_mode_only_stop)
        else $error("mode changed outside stop frame");

    property p_gap_after_stop;
        @(posedge clk_i) disable iff (!rst_n_i)
        (st_r == SIA_STOP_LOW && line_s) |=> !serirq_oe_o ##1 !serirq_oe_o;
    endproperty
    a_gap_after_stop: assert property (p_gap_after_stop)
        else $error("start too soon after stop rise");

    property p_sample_only_phase;
        @(posedge clk_i) disable iff (!rst_n_i)
        (st_r == SIA_DATA && serirq_oe_o && !serirq_o)
        |-> 2'(cnt_r % 6'h3) == SIA_PH_SAMPLE;
    endproperty
    a_sample_only_phase: assert property (p_sample_only_phase)
        else $error("line driven low outside a sample clock");
endmodule

// ---- sia_agent_tb.sv ----
// self-checking bench for the serial interrupt slave agent
module sia_agent_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // stimulus, wire and instances
    // ****************************************************************
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:1] irq = 15'h7FFF;
    logic smi = 1'b0;
    logic [7:0] smi_en = 8'h00;
    logic oe, o, pin, quiet, active, h_drv, h_val, h_frm, line;
    logic p_low = 1'b0;
    logic p_high = 1'b0;
    int fails = 0;
    int checked = 0;
    int cyc = 0;
    always #2 clk = ~clk;
    // open-drain wire with pull-up: any low drive wins
    assign line = ~((oe & ~o) | (h_drv & ~h_val));
    sia_agent dut_u (.clk_i(clk), .rst_n_i(rst_n), .irq_i(irq),
        .smi_i(smi), .smi_enable2_i(smi_en), .serirq_i(line),
        .serirq_o(o), .serirq_oe_o(oe),
        .system_management_irq_pin_o(pin), .quiet_mode_o(quiet),
        .cycle_active_o(active));
    sia_host_model host_u (.clk_i(clk), .line_i(line), .drv_o(h_drv),
        .val_o(h_val), .frames_o(h_frm));
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h exp %h",
                     $time, what, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // hang guard: a full run needs well under a thousand clocks
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            give_verdict();
        end
    end
    // drive shape watch: values read here belong to the previous clock
    always @(posedge clk) begin
        if (p_low && h_frm) cmp({oe, o}, 2'b11, "recovery");
        if (p_low && !h_frm) cmp(oe, 1'b0, "start release");
        if (p_high) cmp(oe, 1'b0, "turn-around");
        if (!h_frm && rst_n) cmp(oe & o, 1'b0, "high outside frames");
        p_low <= oe & ~o;
        p_high <= oe & o;
    end
    // ****************************************************************
    // scenarios
    // ****************************************************************
    function automatic logic [16:1] expect_frames();
        logic [16:1] e;
        e = {irq, 1'b1}; // frame one carries nothing
        e[3] = irq[2] & ~(smi & smi_en[6]);
        return e;
    endfunction
    task automatic run(input int wid, input int stop_w, input bit agent);
        logic [16:1] e;
        e = expect_frames();
        host_u.cycle(wid, stop_w, agent);
        cmp(host_u.seen, e, "frames");
    endtask
    task automatic quiet_watch(input int n);
        repeat (n) begin
            @(posedge clk);
            cmp(oe, 1'b0, "passive agent drove");
        end
    endtask
    task automatic t_first_cycle();
        @(posedge clk);
        irq <= 15'h4A5A; // line 13 low
        repeat (4) @(posedge clk);
        run(4, 3, 1'b0);
        cmp(quiet, 1'b0, "mode after stop 3");
    endtask
    task automatic t_continuous_passive();
        @(posedge clk);
        irq <= 15'h7FFF;
        quiet_watch(30);
        run(8, 2, 1'b0);
        repeat (2) @(posedge clk);
        cmp(quiet, 1'b1, "mode after stop 2");
    endtask
    task automatic t_agent_start();
        @(posedge clk);
        irq[5] <= 1'b0;
        // let the new level land before the expectation is taken
        @(posedge clk);
        run(6, 3, 1'b1);
        cmp(host_u.got_start, 1'b1, "agent start seen");
        cmp(quiet, 1'b0, "back to continuous");
        @(posedge clk);
        irq[1] <= 1'b0;
        quiet_watch(30);
    endtask
    task automatic t_smi();
        int b;
        for (b = 0; b < 4; b++) begin
            @(posedge clk);
            smi <= 1'b1;
            smi_en <= {b[1:0], 6'h00};
            repeat (4) @(posedge clk);
            cmp(pin, !b[1], "smi pin");
        end
        run(5, 3, 1'b0);
        @(posedge clk);
        smi <= 1'b0;
        irq[2] <= 1'b0;
        repeat (4) @(posedge clk);
        cmp(pin, 1'b1, "smi pin idle");
        run(7, 3, 1'b0);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        cmp({oe, pin, quiet, active}, 4'h4, "reset state");
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        cmp({quiet, active}, 2'b00, "idle after reset");
        t_first_cycle();
        t_continuous_passive();
        t_agent_start();
        t_smi();
        give_verdict();
    end
endmodule

// ---- sia_host_model.sv ----
// host controller model for the shared serial interrupt line
module sia_host_model (
    input wire logic clk_i,
    input wire logic line_i,
    output logic drv_o,
    output logic val_o,
    output logic frames_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // host cycle: start extension, frame sampling, stop
    // ****************************************************************
    logic [16:1] seen;
    logic got_start;
    // line released until the bench asks for a cycle
    initial begin
        drv_o = 1'b0;
        val_o = 1'b1;
        frames_o = 1'b0;
        seen = '1;
        got_start = 1'b0;
    end
    // host timing counts clocks from its own start drive; only an agent start is awaited on the wire
    task automatic cycle(input int wid, input int stop_w, input bit agent);
        int k;
        logic [16:1] got;
        got = '1;
        @(posedge clk_i);
        k = 0;
        while (agent && line_i !== 1'b0 && k < 40) begin
            @(posedge clk_i);
            k++;
        end
        got_start = agent && k < 40;
        drv_o <= 1'b1;
        val_o <= 1'b0;
        repeat (agent ? wid - 1 : wid) @(posedge clk_i);
        val_o <= 1'b1;
        frames_o <= 1'b1;
        @(posedge clk_i);
        drv_o <= 1'b0;
        // sixteen frames; the read at edge k sees clock k-1, so frame n
        // is taken at k = 3n, just after its sample clock 3n-1
        for (k = 2; k <= 53; k++) begin
            @(posedge clk_i);
            if (k % 3 == 0 && k <= 48) begin
                got[k / 3] = line_i;
            end
        end
        drv_o <= 1'b1;
        val_o <= 1'b0;
        frames_o <= 1'b0;
        repeat (stop_w) @(posedge clk_i);
        val_o <= 1'b1;
        @(posedge clk_i);
        drv_o <= 1'b0;
        // levels are handed on only once the whole cycle has gone by
        seen = got;
        repeat (4) @(posedge clk_i);
    endtask
endmodule

// ---- sia_pkg.sv ----
// package: constants and carrier types for the serial interrupt slave agent
package sia_pkg;
    // ****************************************************************
    // frame timing
    // ****************************************************************
    localparam int SIA_FRAME_CLKS = 3;
    localparam int SIA_NUM_FRAMES = 16;
    localparam logic [5:0] SIA_LAST_DATA_CLK = 6'h2F; // sample of frame 16
    localparam logic [1:0] SIA_PH_SAMPLE = 2'h2;
    localparam logic [1:0] SIA_PH_RECOVER = 2'h0;
    localparam logic [1:0] SIA_PH_TURN = 2'h1;
    localparam logic [3:0] SIA_STOP_QUIET_W = 4'h2;
    localparam logic [3:0] SIA_STOP_CONT_W = 4'h3;
    localparam logic [3:0] SIA_START_MIN_W = 4'h4;
    localparam int SIA_SMI_FRAME = 3;
    localparam int SIA_SMI_SERIAL_BIT = 6;
    localparam int SIA_SMI_PIN_BIT = 7;
    localparam logic SIA_RESET_QUIET = 1'b0; // continuous after reset
    // ****************************************************************
    // carrier types
    // ****************************************************************
    typedef struct packed {
        logic i;
        logic o;
        logic oe;
    } sia_pin_t;
    typedef enum {
        SIA_IDLE,
        SIA_START_DRV,
        SIA_START_LOW,
        SIA_DATA,
        SIA_STOP_WAIT,
        SIA_STOP_LOW,
        SIA_STOP_GAP
    } sia_state_t;
endpackage

// ---- sia_sync.sv ----
// two-flop synchroniser bank for asynchronous inputs
module sia_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    // ****************************************************************
    // first stage feeds only the second; resets to released (high)
    // ****************************************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_r <= '1;
            s2_r <= '1;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
        end
    end
    assign q_o = s2_r;
endmodule
